// *** aims_mux_select.sv ***
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Sources: external pins, Port 3 groups, amplifier, temperature sensor.
// - Each external pin works single-ended or within a pair.
// - Port 3 analog pins come from per-pin enable bits.
// - Any combination of Port 3 pins may be enabled together.
// - Even enabled pins feed one mux input, odd pins another.
// - Same-parity enabled pins are joined wired-OR on their input.
// - Paired Port 3 group measures even pins minus odd pins.
// - Amplifier output is selected through the common channel code.
// - After reset every input is single-ended, no pairing active.
// - Group entries carry only enabled Port 3 pins.
module aims_mux_select (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    output aims_pkg::aims_route_type  route
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [3:0]  pair_config_q;
    logic [3:0]  pair_config_d;
    logic [3:0]  channel_code_q;
    logic [3:0]  channel_code_d;
    logic [7:0]  port_pin_analog_enable_q;
    logic [7:0]  port_pin_analog_enable_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    aims_pkg::aims_route_type route_q;
    aims_pkg::aims_route_type route_d;

    logic        access;
    logic        lane0_write;
    logic        read_taken;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Every access is answered one cycle after it is presented; the wait
    // cycle lets read data come straight from a flip-flop.
    // A request is taken at the edge where waitrequest is still high. The
    // write lands at that same edge, and the acknowledge flop then drops
    // waitrequest for exactly one cycle. The master must release at the
    // edge that samples waitrequest low; since ack_q blocks a second
    // capture while it is set, a held request is never taken twice.
    // Back-to-back traffic therefore runs at one access per two cycles,
    // which is ample for three configuration registers written rarely.
    // While clk_en is low nothing is taken and waitrequest stays high,
    // so a stalled master simply waits; it is not refused.
    assign access          = (avs_read | avs_write) & clk_en;
    assign avs_waitrequest = ~ack_q;
    assign avs_readdata    = readdata_q;
    assign lane0_write     = avs_write & ~ack_q & clk_en & avs_byteenable[0];
    assign read_taken      = avs_read & ~ack_q & clk_en;

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // The status word mirrors the registered route, so software sees the
    // sources and flags the converter stage is handed (not the pin switches),
    // one cycle after a configuration write has landed.
    assign status_word[3:0]   = route_q.positive_src;
    assign status_word[7:4]   = route_q.negative_src;
    assign status_word[15:8]  = 8'h00;
    assign status_word[16]    = route_q.differential;
    assign status_word[17]    = route_q.twos_complement;
    assign status_word[31:18] = 14'h0000;

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------

    always_comb begin
        pair_config_d            = pair_config_q;
        channel_code_d           = channel_code_q;
        port_pin_analog_enable_d = port_pin_analog_enable_q;
        readdata_d               = readdata_q;
        ack_d                    = 1'b0;
        if (access && !ack_q) begin
            ack_d = 1'b1;
        end
        if (lane0_write) begin
            case (avs_address)
                aims_pkg::REG_PAIR_CONFIG_ADDR: begin
                    // Only the four pairing bits are stored.
                    pair_config_d = avs_writedata[3:0];
                end
                aims_pkg::REG_CHANNEL_SELECT_ADDR: begin
                    channel_code_d = avs_writedata[3:0];
                end
                aims_pkg::REG_PORT_ENABLE_ADDR: begin
                    // Any mix of bits is accepted.
                    port_pin_analog_enable_d = avs_writedata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (read_taken) begin
            case (avs_address)
                aims_pkg::REG_PAIR_CONFIG_ADDR: begin
                    readdata_d = {28'h0000000, pair_config_q};
                end
                aims_pkg::REG_CHANNEL_SELECT_ADDR: begin
                    readdata_d = {28'h0000000, channel_code_q};
                end
                aims_pkg::REG_PORT_ENABLE_ADDR: begin
                    readdata_d = {24'h000000, port_pin_analog_enable_q};
                end
                aims_pkg::REG_ROUTE_STATUS_ADDR: begin
                    // Read-only; writes to this offset fall to default.
                    readdata_d = status_word;
                end
                default: begin
                    readdata_d = aims_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Route decode
    // ------------------------------------------------------------------
    logic [7:0] even_switch;
    logic [7:0] odd_switch;

    // Pins of one parity share a single node, so every enabled pin of that
    // parity is closed at once and the node sees them wired together.
    // The enable register places no limit on how many pins are closed;
    // a user who enables two pins of one parity shorts them through the
    // switches, and the converter sees whatever the stronger source wins.
    // Splitting by index parity keeps the two group nodes disjoint, so a
    // paired measurement never has the same pin on both sides.
    genvar gi;
    generate
        for (gi = 0; gi < aims_pkg::PORT_PIN_COUNT; gi = gi + 1) begin : g_pin
            if (gi % 2 == 0) begin : g_even
                assign even_switch[gi] = port_pin_analog_enable_q[gi];
                assign odd_switch[gi]  = 1'b0;
            end else begin : g_odd
                assign odd_switch[gi]  = port_pin_analog_enable_q[gi];
                assign even_switch[gi] = 1'b0;
            end
        end
    endgenerate

    // The route is rebuilt from the three registers on every cycle, so a
    // change of code or pairing takes effect on the next edge without any
    // sequencing. Every field gets a value on every path; the defaults
    // below leave the negative side on ground and all group switches
    // open, which is the single-ended case for any source.
    // Codes whose pair partner is active keep the lone source, since the
    // selection table gives them no use; that avoids a silent dead code.
    always_comb begin
        route_d                 = route_q;
        route_d.positive_src    = aims_pkg::SRC_GROUND;
        route_d.negative_src    = aims_pkg::SRC_GROUND;
        route_d.differential    = 1'b0;
        route_d.even_pin_switch = 8'h00;
        route_d.odd_pin_switch  = 8'h00;
        if (channel_code_q[3]) begin
            route_d.positive_src = aims_pkg::SRC_TEMP_SENSOR;
        end else begin
            case (channel_code_q)
                aims_pkg::CODE_PIN0: begin
                    route_d.positive_src = aims_pkg::SRC_PIN0;
                    if (pair_config_q[aims_pkg::PINS_0_1_PAIR_BIT]) begin
                        route_d.negative_src = aims_pkg::SRC_PIN1;
                        route_d.differential = 1'b1;
                    end
                end
                aims_pkg::CODE_PIN1: begin
                    // A paired pin's second code has no documented use;
                    // it is left selecting the pin alone.
                    route_d.positive_src = aims_pkg::SRC_PIN1;
                end
                aims_pkg::CODE_PIN2: begin
                    route_d.positive_src = aims_pkg::SRC_PIN2;
                    if (pair_config_q[aims_pkg::PINS_2_3_PAIR_BIT]) begin
                        route_d.negative_src = aims_pkg::SRC_PIN3;
                        route_d.differential = 1'b1;
                    end
                end
                aims_pkg::CODE_PIN3: begin
                    // Same treatment as the first pair's second code.
                    route_d.positive_src = aims_pkg::SRC_PIN3;
                end
                aims_pkg::CODE_AMP: begin
                    route_d.positive_src = aims_pkg::SRC_AMP;
                    if (pair_config_q[aims_pkg::AMP_REF_PAIR_BIT]) begin
                        route_d.negative_src =
                            aims_pkg::SRC_AMP_COMMON_REF;
                        route_d.differential = 1'b1;
                    end
                end
                aims_pkg::CODE_GROUND: begin
                    // With the amplifier paired this code stays on ground,
                    // which gives a harmless reading rather than none.
                    route_d.positive_src = aims_pkg::SRC_GROUND;
                end
                aims_pkg::CODE_EVEN: begin
                    route_d.positive_src    = aims_pkg::SRC_EVEN_GROUP;
                    route_d.even_pin_switch = even_switch;
                    if (pair_config_q[aims_pkg::PORT_GROUP_PAIR_BIT]) begin
                        // Even group minus odd group.
                        route_d.negative_src   = aims_pkg::SRC_ODD_GROUP;
                        route_d.odd_pin_switch = odd_switch;
                        route_d.differential   = 1'b1;
                    end
                end
                aims_pkg::CODE_ODD: begin
                    // The odd group alone, whether or not groups are paired.
                    route_d.positive_src   = aims_pkg::SRC_ODD_GROUP;
                    route_d.odd_pin_switch = odd_switch;
                end
                default: begin
                    route_d.positive_src = aims_pkg::SRC_TEMP_SENSOR;
                end
            endcase
        end
        route_d.twos_complement = route_d.differential;
    end

    assign route = route_q;

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // Bus and configuration state. Reset needs clk_en high, like every
    // other change of state, so a frozen block also ignores reset.
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (rst) begin
                // Reset leaves all inputs single-ended.
                pair_config_q <= aims_pkg::PAIR_CONFIG_RESET[3:0];
                channel_code_q <= aims_pkg::CHANNEL_SELECT_RESET[3:0];
                port_pin_analog_enable_q <= aims_pkg::PORT_ENABLE_RESET;
                ack_q                    <= 1'b0;
                readdata_q               <= 32'h0000_0000;
            end else begin
                pair_config_q            <= pair_config_d;
                channel_code_q           <= channel_code_d;
                port_pin_analog_enable_q <= port_pin_analog_enable_d;
                ack_q                    <= ack_d;
                readdata_q               <= readdata_d;
            end
        end
    end

    // Route state. It is kept apart from the bus so that the converter
    // side sees a registered, glitch-free selection at all times.
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (rst) begin
                route_q.positive_src    <= aims_pkg::SRC_PIN0;
                route_q.negative_src    <= aims_pkg::SRC_GROUND;
                route_q.differential    <= 1'b0;
                route_q.twos_complement <= 1'b0;
                route_q.even_pin_switch <= 8'h00;
                route_q.odd_pin_switch  <= 8'h00;
            end else begin
                route_q                 <= route_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Limitations
    // ------------------------------------------------------------------
    // Only byte lane 0 carries write data; a write with that lane disabled is
    // acknowledged and stores nothing. Unmapped reads return zero and
    // unmapped writes are dropped. Holding clk_en low stalls any bus
    // request indefinitely, so the host must not park the block while
    // software still expects an answer.

endmodule

`default_nettype wire

// *** aims_pkg.sv ***
package aims_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_PAIR_CONFIG_ADDR    = 4'h0;
    localparam logic [3:0] REG_CHANNEL_SELECT_ADDR = 4'h4;
    localparam logic [3:0] REG_PORT_ENABLE_ADDR    = 4'h8;
    localparam logic [3:0] REG_ROUTE_STATUS_ADDR   = 4'hC;

    localparam logic [7:0] PAIR_CONFIG_RESET    = 8'h00;
    localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h00;
    localparam logic [7:0] PORT_ENABLE_RESET    = 8'h00;
    localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PINS_0_1_PAIR_BIT   = 0;
    localparam int PINS_2_3_PAIR_BIT   = 1;
    localparam int AMP_REF_PAIR_BIT    = 2;
    localparam int PORT_GROUP_PAIR_BIT = 3;
    localparam int CONFIG_FIELD_WIDTH  = 4;
    localparam int CHANNEL_CODE_WIDTH  = 4;
    localparam int PORT_PIN_COUNT      = 8;

    // ------------------------------------------------------------------
    // Channel codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CODE_PIN0      = 4'h0;
    localparam logic [3:0] CODE_PIN1      = 4'h1;
    localparam logic [3:0] CODE_PIN2      = 4'h2;
    localparam logic [3:0] CODE_PIN3      = 4'h3;
    localparam logic [3:0] CODE_AMP       = 4'h4;
    localparam logic [3:0] CODE_GROUND    = 4'h5;
    localparam logic [3:0] CODE_EVEN      = 4'h6;
    localparam logic [3:0] CODE_ODD       = 4'h7;

    typedef enum logic [3:0] {
        SRC_PIN0,
        SRC_PIN1,
        SRC_PIN2,
        SRC_PIN3,
        SRC_AMP,
        SRC_GROUND,
        SRC_EVEN_GROUP,
        SRC_ODD_GROUP,
        SRC_TEMP_SENSOR,
        SRC_AMP_COMMON_REF
    } aims_source_type;

    // Route presented to the converter input stage.
    typedef struct packed {
        aims_source_type positive_src;
        aims_source_type negative_src;
        logic            differential;
        logic            twos_complement;
        logic [7:0]      even_pin_switch;
        logic [7:0]      odd_pin_switch;
    } aims_route_type;

endpackage

// *** aims_mux_select_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module aims_mux_select_monitor (
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire logic                     clk_en,
    input wire logic [3:0]               avs_address,
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic [31:0]              avs_writedata,
    input wire logic [3:0]               avs_byteenable,
    input wire logic [31:0]              avs_readdata,
    input wire logic                     avs_waitrequest,
    input wire aims_pkg::aims_route_type route
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest && clk_en;
    endsequence
    sequence s_temp_sel;
        avs_write && !avs_waitrequest && avs_address == 4'h4
            && avs_byteenable[0] && avs_writedata[3];
    endsequence
    a_ack_next: assert property (s_req |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_reset_route: assert property ($fell(rst) |-> !route.differential
        && route.even_pin_switch == 8'h00 && route.odd_pin_switch == 8'h00)
        else $error("route not single ended after reset");
    a_temp_route: assert property (s_temp_sel |-> ##[1:2]
        route.positive_src == aims_pkg::SRC_TEMP_SENSOR)
        else $error("top code bit did not pick temperature");
    a_pair_signed: assert property (route.differential == route.twos_complement)
        else $error("signed flag differs from pairing");
    a_even_owner: assert property (route.even_pin_switch != 8'h00 |->
        route.positive_src == aims_pkg::SRC_EVEN_GROUP)
        else $error("even switches closed without even channel");
    a_odd_owner: assert property (route.odd_pin_switch != 8'h00 |->
        route.positive_src == aims_pkg::SRC_ODD_GROUP
        || route.negative_src == aims_pkg::SRC_ODD_GROUP)
        else $error("odd switches closed without odd channel");
    a_amp_ref: assert property (route.differential
        && route.positive_src == aims_pkg::SRC_AMP
        |-> route.negative_src == aims_pkg::SRC_AMP_COMMON_REF)
        else $error("amplifier pair lacks reference");
    a_group_pair: assert property (route.differential
        && route.positive_src == aims_pkg::SRC_EVEN_GROUP
        |-> route.negative_src == aims_pkg::SRC_ODD_GROUP)
        else $error("even group pair lacks odd group");
endmodule
bind aims_mux_select aims_mux_select_monitor u_mon (.clk_sys(clk_sys),
    .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .route(route));
`default_nettype wire

// *** aims_adc_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aims_adc_stage_model (
    input wire aims_pkg::aims_route_type route,
    output logic signed [12:0]           sample
);
    // Each port pin owns one bit, so a shorted group shows every pin in it.
    function automatic logic [12:0] level(input aims_pkg::aims_source_type s,
                                          input logic [7:0] sw);
        case (s)
            aims_pkg::SRC_EVEN_GROUP,
            aims_pkg::SRC_ODD_GROUP: level = {2'h0, sw, 3'h0};
            aims_pkg::SRC_GROUND: level = 13'h0000;
            default: level = {4'h0, 1'b1, s, 4'h0};
        endcase
    endfunction
    always_comb begin
        sample = level(route.positive_src,
            route.positive_src == aims_pkg::SRC_ODD_GROUP
            ? route.odd_pin_switch : route.even_pin_switch);
        if (route.differential) begin
            sample = sample - level(route.negative_src, route.odd_pin_switch);
        end
    end
endmodule
`default_nettype wire

// *** test_adc_input_mux_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_mux_select;
    logic                     clk_sys = 1'b0;
    logic                     rst = 1'b1;
    logic                     clk_en = 1'b1;
    logic                     avs_read = 1'b0;
    logic                     avs_write = 1'b0;
    logic                     avs_waitrequest;
    logic [3:0]               avs_address = 4'h0;
    logic [3:0]               avs_byteenable = 4'h1;
    logic [31:0]              avs_writedata = 32'h0;
    logic [31:0]              avs_readdata;
    logic [31:0]              rd;
    aims_pkg::aims_route_type route;
    logic signed [12:0]       sample;
    int                       n_fail = 0;
    int                       checked = 0;
    aims_mux_select dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .route(route));
    aims_adc_stage_model u_stage (.route(route), .sample(sample));
    always #2.5 clk_sys = ~clk_sys;
    task automatic print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, input logic be);
        int i;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h0, be};
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            print_verdict();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic status(input logic [3:0] pos, neg, input logic dif);
        bus(1'b0, 4'hC, 8'h00, 1'b1);
        check("status", rd, {14'h0, dif, dif, 8'h00, neg, pos});
        check("route", {route.positive_src, route.negative_src,
            route.differential, route.twos_complement}, {pos, neg, dif, dif});
    endtask
    task automatic t_reset;
        bus(1'b0, 4'h0, 8'h00, 1'b1);
        check("pair config", rd, 32'h0);
        status(4'h0, aims_pkg::SRC_GROUND, 1'b0);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, 4'h4, 8'hF0 | 8'(c), 1'b1);
            bus(1'b0, 4'h4, 8'h00, 1'b1);
            check("channel", rd, 32'(c));
            status(c < 8 ? 4'(c) : 4'h8, aims_pkg::SRC_GROUND, 1'b0);
        end
    endtask
    task automatic t_pairs;
        logic [3:0] code[4] = '{4'h0, 4'h2, 4'h4, 4'h6};
        logic [3:0] neg[4] = '{4'h1, 4'h3, 4'h9, 4'h7};
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 4'h0, 8'hF0 | (8'h01 << k), 1'b1);
            bus(1'b0, 4'h0, 8'h00, 1'b1);
            check("pair config", rd, 32'h1 << k);
            bus(1'b1, 4'h4, {4'h0, code[k]}, 1'b1);
            status(code[k], neg[k], 1'b1);
        end
    endtask
    task automatic t_port;
        bus(1'b1, 4'h8, 8'hA5, 1'b1);
        bus(1'b1, 4'h8, 8'h33, 1'b0);
        bus(1'b0, 4'h8, 8'h00, 1'b1);
        check("pin enable", rd, 32'hA5);
        bus(1'b1, 4'h0, 8'h00, 1'b1);
        bus(1'b1, 4'h4, 8'h06, 1'b1);
        check("even sw", {route.even_pin_switch, route.odd_pin_switch}, 16'h0500);
        bus(1'b1, 4'h4, 8'h07, 1'b1);
        check("odd sw", {route.even_pin_switch, route.odd_pin_switch}, 16'h00A0);
        bus(1'b1, 4'h0, 8'h08, 1'b1);
        bus(1'b1, 4'h4, 8'h06, 1'b1);
        check("pair sw", {route.even_pin_switch, route.odd_pin_switch}, 16'h05A0);
        check("sample", 13'(sample), 13'h0028 - 13'h0500);
        bus(1'b1, 4'h2, 8'hFF, 1'b1);
        bus(1'b0, 4'h2, 8'h00, 1'b1);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_freeze;
        int i;
        clk_en <= 1'b0;
        avs_address <= 4'h4;
        avs_writedata <= 32'h0000_0003;
        avs_byteenable <= 4'h1;
        avs_write <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("frozen wait", 32'(avs_waitrequest), 32'h1);
        check("frozen route", 32'(route.positive_src), 32'h6);
        clk_en <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            print_verdict();
        end
        avs_write <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("thawed route", 32'(route.positive_src), 32'h3);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_pairs();
        t_port();
        t_freeze();
        print_verdict();
    end
endmodule
`default_nettype wire
